// ==== hw/dbg_uart_pkg.sv ====
// shared constants and state types for the debug serial port
package dbg_uart_pkg;
	// register indices as printed; byte address is four times the index
	localparam int unsigned IDX_STATUS = 32'h0000c028;
	localparam int unsigned IDX_LOW = 32'h0000c029;
	localparam int unsigned IDX_HIGH = 32'h0000c02a;
	localparam int unsigned IDX_DIV = 32'h0000c02b;
	localparam int ADDR_W = 18;
	localparam logic [17:0] ADDR_STATUS = 18'(IDX_STATUS * 4);
	localparam logic [17:0] ADDR_LOW = 18'(IDX_LOW * 4);
	localparam logic [17:0] ADDR_HIGH = 18'(IDX_HIGH * 4);
	localparam logic [17:0] ADDR_DIV = 18'(IDX_DIV * 4);
	// status bit positions
	localparam int ST_OVERRUN = 3;
	localparam int ST_RX_FULL = 2;
	localparam int ST_TX_FULL = 1;
	localparam int ST_TX_RUN = 0;
	// divider fields and reset value
	localparam int DIV_PRE_LSB = 8;
	localparam int DIV_BIT_LSB = 0;
	localparam logic [15:0] DIV_RESET = 16'h0000;
	// frame layout: start, eight data, stop
	localparam logic [3:0] FRAME_BITS = 4'ha;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic LINE_IDLE = 1'b1;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

	// whole state of the port in one packed word
	typedef struct packed {
		logic wait_q;
		logic [31:0] rdata;
		logic [15:0] div;
		logic [7:0] pre_cnt;
		logic [7:0] bit_cnt;
		logic tx_run;
		logic tx_full;
		logic [7:0] tx_hold;
		logic [8:0] tx_sh;
		logic [3:0] tx_n;
		logic txd;
		logic tx_irq;
		rx_state_e rx_st;
		logic rx_prev;
		logic [7:0] rx_cnt;
		logic [3:0] rx_n;
		logic [7:0] rx_sh;
		logic [7:0] rx_byte;
		logic rx_full;
		logic rx_ovr;
		logic rx_irq;
	} uart_state_s;
endpackage

// ==== hw/debug_serial_uart.sv ====
// debug serial port: avalon register slave, two-stage baud divider, transmitter and receiver
// How it works
// (RQ1) idle transmit line stays high
// (RQ2) frame: start low, eight lsb-first, stop high
// (RQ3) overrun set when new byte hits unread
// (RQ4) receive full until data register read
// (RQ5) transmit full while holding byte waits
// (RQ6) transmitter running while shifter sends
// (RQ7) low data read gives byte, upper zero
// (RQ8) low data write takes bits 7:0 only
// (RQ9) write when idle loads shifter, pulses irq
// (RQ10) write when busy holds byte until done
// (RQ11) high data register uses bits 15:8
// (RQ12) divider: prescale 15:8, bit 7:0, resets zero
// (RQ13) software sets bit divider 6 to 255
// (RQ14) bit rate is clock/((pre+1)*bit)
// (RQ15) receiver samples at prescaler output rate
// (RQ16) software never writes while transmit full
// (RQ17) holding empties when byte enters shifter
// (RQ18) idle receiver takes falling edge as start
// (RQ19) data bits sampled mid-bit, lsb first
// (RQ20) good stop: store, irq, copy full, set full
// (RQ21) receiver returns idle after each character
// (RQ22) low stop sample discards the character
// (RQ23) each irq is a one-cycle pulse
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module debug_serial_uart (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [17:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic rxd,
	output logic txd,
	output logic tx_irq,
	output logic rx_irq
);
	dbg_uart_pkg::uart_state_s s_q, s_d;

	logic req, pre_tick, bit_tick, tx_load, rx_done, tx_end;
	logic [7:0] pre_div, bit_div, tx_byte;
	logic [15:0] wd;

	// request is taken on the cycle the wait flop is still high, so effects and read data line up
	assign req = (avs_read | avs_write) & s_q.wait_q;
	assign pre_div = s_q.div[dbg_uart_pkg::DIV_PRE_LSB +: 8];
	assign bit_div = s_q.div[dbg_uart_pkg::DIV_BIT_LSB +: 8];
	assign wd = avs_writedata[15:0];

	// first stage ticks every pre_div+1 clocks; second stage every bit_div first-stage ticks [RQ14]
	assign pre_tick = s_q.pre_cnt == pre_div;
	assign bit_tick = pre_tick & (s_q.bit_cnt == 8'(bit_div - 8'h01));

	// last bit tick of a frame: the shifter is free again in the same cycle
	assign tx_end = s_q.tx_run & bit_tick & (s_q.tx_n == 4'(dbg_uart_pkg::FRAME_BITS - 4'h1));

	always_comb begin
		s_d = s_q;
		tx_load = 1'b0;
		tx_byte = s_q.tx_hold;
		rx_done = 1'b0;
		s_d.tx_irq = 1'b0;
		s_d.rx_irq = 1'b0;
		// bus handshake: one wait cycle per request
		s_d.wait_q = s_q.wait_q ? !(avs_read | avs_write) : 1'b1;
		// prescaler counts every clock, restarted when the shifter loads
		s_d.pre_cnt = pre_tick ? 8'h00 : 8'(s_q.pre_cnt + 8'h01);
		if (pre_tick) begin
			s_d.bit_cnt = bit_tick ? 8'h00 : 8'(s_q.bit_cnt + 8'h01);
		end

		// transmitter shifting on bit ticks [RQ2]
		if (s_q.tx_run && bit_tick) begin
			if (s_q.tx_n == 4'(dbg_uart_pkg::FRAME_BITS - 4'h1)) begin
				s_d.tx_run = 1'b0;
				s_d.txd = dbg_uart_pkg::LINE_IDLE; // [RQ1]
				if (s_q.tx_full) begin
					tx_load = 1'b1; // [RQ10]
				end
			end else begin
				s_d.txd = s_q.tx_sh[0];
				s_d.tx_sh = {1'b1, s_q.tx_sh[8:1]};
				s_d.tx_n = 4'(s_q.tx_n + 4'h1);
			end
		end

		// receiver, advanced only at the first-stage rate [RQ15]
		if (pre_tick) begin
			s_d.rx_prev = rxd;
			s_d.rx_cnt = 8'(s_q.rx_cnt + 8'h01);
			case (s_q.rx_st)
				dbg_uart_pkg::RX_IDLE: begin
					if (s_q.rx_prev && !rxd) begin
						s_d.rx_st = dbg_uart_pkg::RX_START; // [RQ18]
						s_d.rx_cnt = 8'h00;
					end
				end
				dbg_uart_pkg::RX_START: begin
					// half a bit is bit_div/2 ticks counted from the detection tick, hence the minus one
					if (s_q.rx_cnt >= 8'((bit_div >> 1) - 8'h01)) begin
						// glitch shorter than half a bit is not a start
						s_d.rx_st = rxd ? dbg_uart_pkg::RX_IDLE : dbg_uart_pkg::RX_DATA;
						s_d.rx_cnt = 8'h00;
						s_d.rx_n = 4'h0;
					end
				end
				dbg_uart_pkg::RX_DATA: begin
					if (s_q.rx_cnt == 8'(bit_div - 8'h01)) begin
						s_d.rx_cnt = 8'h00;
						s_d.rx_sh = {rxd, s_q.rx_sh[7:1]}; // [RQ19]
						s_d.rx_n = 4'(s_q.rx_n + 4'h1);
						if (s_q.rx_n == 4'(dbg_uart_pkg::DATA_BITS - 4'h1)) begin
							s_d.rx_st = dbg_uart_pkg::RX_STOP;
						end
					end
				end
				dbg_uart_pkg::RX_STOP: begin
					if (s_q.rx_cnt == 8'(bit_div - 8'h01)) begin
						s_d.rx_st = dbg_uart_pkg::RX_IDLE; // [RQ21]
						rx_done = rxd; // low stop discards the byte [RQ22]
					end
				end
				default: s_d.rx_st = dbg_uart_pkg::RX_IDLE;
			endcase
		end

		// register reads and writes
		if (req && avs_read) begin
			case (avs_address)
				dbg_uart_pkg::ADDR_STATUS: s_d.rdata = {28'h0000000, s_q.rx_ovr, s_q.rx_full, s_q.tx_full, s_q.tx_run};
				dbg_uart_pkg::ADDR_LOW: s_d.rdata = {24'h000000, s_q.rx_byte}; // [RQ7]
				dbg_uart_pkg::ADDR_HIGH: s_d.rdata = {16'h0000, s_q.rx_byte, 8'h00}; // [RQ11]
				dbg_uart_pkg::ADDR_DIV: s_d.rdata = {16'h0000, s_q.div};
				default: s_d.rdata = 32'h00000000;
			endcase
			if (avs_address == dbg_uart_pkg::ADDR_LOW || avs_address == dbg_uart_pkg::ADDR_HIGH) begin
				s_d.rx_full = 1'b0; // [RQ4]
			end
		end
		if (req && avs_write) begin
			if (avs_address == dbg_uart_pkg::ADDR_DIV) begin
				s_d.div = wd; // [RQ12]
			end
			if (avs_address == dbg_uart_pkg::ADDR_LOW || avs_address == dbg_uart_pkg::ADDR_HIGH) begin
				// a write in the cycle a frame ends counts as a write to an idle shifter, so nothing is stranded
				if ((!s_q.tx_run || tx_end) && !s_q.tx_full) begin
					// byte picked from the lane of the register written [RQ8] [RQ11]
					tx_byte = (avs_address == dbg_uart_pkg::ADDR_LOW) ? wd[7:0] : wd[15:8];
					tx_load = 1'b1; // [RQ9]
				end else if (!s_q.tx_full) begin
					// runs only mid-frame with tx_end low, so the byte waits in tx_hold and tx_byte is left untouched
					s_d.tx_full = 1'b1; // [RQ5] [RQ10]
					s_d.tx_hold = (avs_address == dbg_uart_pkg::ADDR_LOW) ? wd[7:0] : wd[15:8];
				end
			end
		end

		// loading the shifter empties the holding register and starts a frame [RQ17]
		if (tx_load) begin
			s_d.tx_full = 1'b0;
			s_d.tx_run = 1'b1; // [RQ6]
			s_d.txd = 1'b0;
			s_d.tx_sh = {1'b1, tx_byte};
			s_d.tx_n = 4'h0;
			s_d.bit_cnt = 8'h00;
			s_d.pre_cnt = 8'h00;
			s_d.tx_irq = 1'b1; // [RQ23]
		end

		// new byte wins over a read in the same cycle [RQ3] [RQ20]
		if (rx_done) begin
			s_d.rx_byte = s_q.rx_sh;
			s_d.rx_ovr = s_q.rx_full;
			s_d.rx_full = 1'b1;
			s_d.rx_irq = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{wait_q: 1'b1, div: dbg_uart_pkg::DIV_RESET, txd: dbg_uart_pkg::LINE_IDLE,
				rx_prev: dbg_uart_pkg::LINE_IDLE, rx_st: dbg_uart_pkg::RX_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// every output comes straight from the state flops
	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.wait_q;
	assign txd = s_q.txd;
	assign tx_irq = s_q.tx_irq;
	assign rx_irq = s_q.rx_irq;

	// checks next to the logic
	sequence s_low_write_idle;
		req && avs_write && avs_address == dbg_uart_pkg::ADDR_LOW && !s_q.tx_run && !s_q.tx_full;
	endsequence
	sequence s_frame_start;
		tx_irq && !txd && s_q.tx_run;
	endsequence

	property p_idle_high;
		@(posedge clk) disable iff (!rst_n) !s_q.tx_run |-> txd;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("tx line low while idle"); // [RQ1]

	property p_start_low;
		@(posedge clk) disable iff (!rst_n) $rose(s_q.tx_run) |-> !txd && tx_irq;
	endproperty
	a_start_low: assert property (p_start_low) else $error("frame did not open with start bit"); // [RQ2]

	property p_load_idle;
		@(posedge clk) disable iff (!rst_n) s_low_write_idle |=> s_frame_start ##1 !tx_irq;
	endproperty
	a_load_idle: assert property (p_load_idle) else $error("idle write did not start a frame"); // [RQ9]

	property p_hold_busy;
		@(posedge clk) disable iff (!rst_n)
			req && avs_write && avs_address == dbg_uart_pkg::ADDR_LOW && s_q.tx_run && !s_q.tx_full && !tx_end
			|=> s_q.tx_full && s_q.tx_hold == $past(avs_writedata[7:0]);
	endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("busy write not held"); // [RQ10]

	property p_full_needs_run;
		@(posedge clk) disable iff (!rst_n) s_q.tx_full |-> s_q.tx_run;
	endproperty
	a_full_needs_run: assert property (p_full_needs_run) else $error("transmit full while idle"); // [RQ5]

	property p_rx_store;
		@(posedge clk) disable iff (!rst_n) rx_irq |-> s_q.rx_full && s_q.rx_ovr == $past(s_q.rx_full);
	endproperty
	a_rx_store: assert property (p_rx_store) else $error("receive flags wrong after byte"); // [RQ20]

	property p_rx_clear;
		@(posedge clk) disable iff (!rst_n)
			req && avs_read && avs_address == dbg_uart_pkg::ADDR_LOW && !rx_done |=> !s_q.rx_full;
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("receive full not cleared by read"); // [RQ4]

	property p_low_read;
		@(posedge clk) disable iff (!rst_n)
			req && avs_read && avs_address == dbg_uart_pkg::ADDR_LOW
			|=> !avs_waitrequest && avs_readdata[31:8] == 24'h000000;
	endproperty
	a_low_read: assert property (p_low_read) else $error("low data read upper bits set"); // [RQ7]

	property p_div_write;
		@(posedge clk) disable iff (!rst_n)
			req && avs_write && avs_address == dbg_uart_pkg::ADDR_DIV |=> s_q.div == $past(avs_writedata[15:0]);
	endproperty
	a_div_write: assert property (p_div_write) else $error("divider not written"); // [RQ12]

	property p_irq_pulse;
		@(posedge clk) disable iff (!rst_n) (tx_irq |=> !tx_irq) and (rx_irq |=> !rx_irq);
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle"); // [RQ23]

	// bus handshake: one wait cycle, then a single ready cycle
	property p_wait_answer;
		@(posedge clk) disable iff (!rst_n)
			req |=> !avs_waitrequest;
	endproperty
	a_wait_answer: assert property (p_wait_answer) else $error("request not answered next cycle"); // [RQ7]

	property p_wait_release;
		@(posedge clk) disable iff (!rst_n)
			!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_release: assert property (p_wait_release) else $error("ready held more than one cycle"); // [RQ7]

	// busy write to the high register lands in the holding register from the upper lane
	property p_hold_busy_high;
		@(posedge clk) disable iff (!rst_n)
			req && avs_write && avs_address == dbg_uart_pkg::ADDR_HIGH && s_q.tx_run && !s_q.tx_full && !tx_end
			|=> s_q.tx_full && s_q.tx_hold == $past(avs_writedata[15:8]);
	endproperty
	a_hold_busy_high: assert property (p_hold_busy_high) else $error("busy high write not held"); // [RQ11]

	// held byte moves on as the frame ends and the holding register empties
	property p_full_load;
		@(posedge clk) disable iff (!rst_n)
			s_q.tx_full && tx_end
			|=> !s_q.tx_full && tx_irq && !txd && s_q.tx_run;
	endproperty
	a_full_load: assert property (p_full_load) else $error("held byte not loaded at frame end"); // [RQ17]

	property p_low_lane;
		@(posedge clk) disable iff (!rst_n)
			s_low_write_idle |=> s_q.tx_sh[7:0] == $past(avs_writedata[7:0]);
	endproperty
	a_low_lane: assert property (p_low_lane) else $error("low write took wrong bits"); // [RQ8]

	property p_run_with_irq;
		@(posedge clk) disable iff (!rst_n)
			tx_irq |-> s_q.tx_run;
	endproperty
	a_run_with_irq: assert property (p_run_with_irq) else $error("transmit irq without running"); // [RQ6]

	// status read shows the four flags as they stood when the read was taken
	property p_status_read;
		@(posedge clk) disable iff (!rst_n)
			req && avs_read && avs_address == dbg_uart_pkg::ADDR_STATUS
			|=> avs_readdata == {28'h0000000, $past(s_q.rx_ovr), $past(s_q.rx_full), $past(s_q.tx_full),
				$past(s_q.tx_run)};
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong"); // [RQ3] [RQ4] [RQ5] [RQ6]

	property p_high_read;
		@(posedge clk) disable iff (!rst_n)
			req && avs_read && avs_address == dbg_uart_pkg::ADDR_HIGH
			|=> avs_readdata == {16'h0000, $past(s_q.rx_byte), 8'h00};
	endproperty
	a_high_read: assert property (p_high_read) else $error("high data read wrong"); // [RQ11]

	// receiver steps: start detection, data shift, stop handling
	sequence s_stop_sample;
		s_q.rx_st == dbg_uart_pkg::RX_STOP && pre_tick && s_q.rx_cnt == 8'(bit_div - 8'h01);
	endsequence

	property p_start_detect;
		@(posedge clk) disable iff (!rst_n)
			s_q.rx_st == dbg_uart_pkg::RX_IDLE && pre_tick && s_q.rx_prev && !rxd
			|=> s_q.rx_st == dbg_uart_pkg::RX_START;
	endproperty
	a_start_detect: assert property (p_start_detect) else $error("falling edge not taken as start"); // [RQ18]

	property p_data_shift;
		@(posedge clk) disable iff (!rst_n)
			s_q.rx_st == dbg_uart_pkg::RX_DATA && pre_tick && s_q.rx_cnt == 8'(bit_div - 8'h01)
			|=> s_q.rx_sh[7] == $past(rxd);
	endproperty
	a_data_shift: assert property (p_data_shift) else $error("data bit not shifted in"); // [RQ19]

	property p_good_stop;
		@(posedge clk) disable iff (!rst_n)
			s_stop_sample ##0 rxd |=> rx_irq && s_q.rx_full && s_q.rx_byte == $past(s_q.rx_sh);
	endproperty
	a_good_stop: assert property (p_good_stop) else $error("good stop did not store byte"); // [RQ20]

	property p_bad_stop;
		@(posedge clk) disable iff (!rst_n)
			s_stop_sample ##0 !rxd |=> !rx_irq && $stable(s_q.rx_byte);
	endproperty
	a_bad_stop: assert property (p_bad_stop) else $error("low stop not discarded"); // [RQ22]

	property p_back_idle;
		@(posedge clk) disable iff (!rst_n)
			s_stop_sample |=> s_q.rx_st == dbg_uart_pkg::RX_IDLE;
	endproperty
	a_back_idle: assert property (p_back_idle) else $error("receiver not idle after stop"); // [RQ21]
endmodule

// ==== tb/serial_peer.sv ====
// serial terminal model facing the port's txd and rxd lines
`timescale 1ns/1ps
module serial_peer #(parameter int BIT_T = 12) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd,
	output logic got,
	output logic [8:0] frame
);
	logic [8:0] sh;
	// line rests high until a frame is asked
	initial begin
		rxd = 1'b1;
		got = 1'b0;
		frame = 9'h000;
	end
	// start low, data lsb first, chosen stop level, then idle high again
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BIT_T - 1) @(posedge clk);
		end
		@(posedge clk);
		rxd <= 1'b1;
	endtask
	// mid-bit sampling from the start edge; a wrong bit period shows up as wrong data
	initial begin
		forever begin
			@(negedge txd);
			repeat (BIT_T / 2) @(posedge clk);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_T) @(posedge clk);
				sh[i] = txd;
			end
			frame <= sh;
			got <= 1'b1;
			@(posedge clk);
			got <= 1'b0;
		end
	end
endmodule

// ==== tb/debug_serial_uart_tb_top.sv ====
// self-checking bench for the debug serial port
`timescale 1ns/1ps
module debug_serial_uart_tb_top;
	localparam logic [7:0] PRE = 8'h01;
	localparam logic [7:0] BITD = 8'h06;
	localparam int BIT_T = 12; // (pre+1)*bit divider
	localparam logic [17:0] A_ST = dbg_uart_pkg::ADDR_STATUS;
	localparam logic [17:0] A_LO = dbg_uart_pkg::ADDR_LOW;
	localparam logic [17:0] A_HI = dbg_uart_pkg::ADDR_HIGH;
	localparam logic [17:0] A_DV = dbg_uart_pkg::ADDR_DIV;
	logic clk, rst_n, avs_read, avs_write, avs_waitrequest, rxd, txd, tx_irq, rx_irq, got;
	logic [17:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, r;
	logic [8:0] frame;
	logic [7:0] b[4];
	logic [31:0] exp_rd[$];
	logic [7:0] exp_tx[$];
	int fail_count, checks_done, n_tx, n_rx;
	int seed = 32'h699a6f45;
	debug_serial_uart u_debug_serial_uart (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd),
		.tx_irq(tx_irq), .rx_irq(rx_irq));
	serial_peer #(.BIT_T(BIT_T)) u_serial_peer (.clk(clk), .txd(txd), .rxd(rxd), .got(got), .frame(frame));
	// free-running 20 mhz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, g, e);
		end
	endtask
	// one avalon cycle; no cycle count assumed, only waitrequest ends the wait
	task automatic bus(input logic wr, input logic [17:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [17:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic conclude();
		$display("counts: checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// results are matched against the oldest note as they appear; irq pulses are counted per cycle
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) check(avs_readdata, exp_rd.pop_front(), "read");
		if (got === 1'b1) check({23'h0, frame}, {23'h1, exp_tx.pop_front()}, "serial frame");
		if (tx_irq === 1'b1) n_tx++;
		if (rx_irq === 1'b1) n_rx++;
	end
	// whole run is near 800 cycles; the margin covers a stalled bus
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 18'h0;
		avs_writedata = 32'h0;
		for (int i = 0; i < 4; i++) b[i] = 8'($random(seed));
		r = $random(seed);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// reset values, unmapped read, divider set up
		rd(A_ST, 32'h0);
		rd(A_DV, 32'h0);
		rd(18'h00010, 32'h0);
		bus(1'b1, A_DV, {r[31:16], PRE, BITD});
		rd(A_DV, {16'h0, PRE, BITD});
		$display("test registers done");
		// back-to-back writes: second waits in the holding register, stray bits ignored
		exp_tx.push_back(b[0]);
		bus(1'b1, A_LO, {r[31:8], b[0]});
		exp_tx.push_back(b[1]);
		bus(1'b1, A_HI, {r[31:16], b[1], r[7:0]});
		rd(A_ST, 32'h3);
		repeat (11 * BIT_T) @(posedge clk);
		rd(A_ST, 32'h1);
		repeat (11 * BIT_T) @(posedge clk);
		rd(A_ST, 32'h0);
		check({31'h0, txd}, 32'h1, "idle line");
		check(n_tx, 2, "tx irq pulses");
		$display("test transmit done");
		// receive: full, overrun, bad stop discarded, overrun copy cleared
		u_serial_peer.send(b[2], 1'b1);
		rd(A_ST, 32'h4);
		u_serial_peer.send(b[3], 1'b1);
		rd(A_ST, 32'hc);
		rd(A_LO, {24'h0, b[3]});
		rd(A_ST, 32'h8);
		u_serial_peer.send(b[0], 1'b0);
		rd(A_ST, 32'h8);
		u_serial_peer.send(b[1], 1'b1);
		rd(A_ST, 32'h4);
		rd(A_HI, {16'h0, b[1], 8'h0});
		rd(A_ST, 32'h0);
		check(n_rx, 3, "rx irq pulses");
		$display("test receive done");
		conclude();
	end
endmodule
